// ### dv/aur_line_model.sv
// Remote serial transmitter driving the receive line
`timescale 1ns/100ps
module aur_line_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input wire    sys_clk,
  // Serial line, idle high
  output logic  line
);
  initial line = 1'b1;
  // Level held for n bit times, changed just after an edge
  task hold(input logic lvl, input int n);
    line <= lvl;
    repeat (n * BIT_CLKS) @(posedge sys_clk);
  endtask
  // Start, data LSB first, stop, then an idle bit
  task frame(input logic [8:0] d, input int nb, input logic stp);
    hold(1'b0, 1);
    for (int i = 0; i < nb; i++) hold(d[i], 1);
    hold(stp, 1);
    hold(1'b1, 1); // Gap so a low stop is not a start
  endtask
  // All-zero break, then a gap for start-up
  task brk(input int n);
    hold(1'b0, n);
    hold(1'b1, 2);
  endtask
endmodule

// ### dv/aur_rx_chk.sv
// Port-level assertions for the serial receiver
`timescale 1ns/100ps
module aur_rx_chk (
  // Clock and reset
  input wire        sys_clk,
  input wire        reset_n,
  // APB
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Interrupts
  input wire        rcv_irq_high,
  input wire        rcv_irq_low
);
  // ========
  // Shared clocking
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ========
  // Access steps
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  sequence s_acc; psel && penable && pready; endsequence
  property p_ready_once; s_setup |=> s_answer; endproperty
  property p_idle_quiet; !psel |=> !pready; endproperty
  property p_hi_zero; prdata[31:8] == 24'h0; endproperty
  property p_err_clean; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_unmapped; pready && paddr > 12'h020 |-> pslverr; endproperty
  property p_mapped;
    pready && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_rd_clear; s_acc |=> prdata == 32'h0; endproperty
  property p_irq_excl; !(rcv_irq_high && rcv_irq_low); endproperty
  // Requests only drop after a register access two edges back
  property p_irq_fall;
    $fell(rcv_irq_low) || $fell(rcv_irq_high) |->
      $past(psel && penable && pready, 2);
  endproperty

  a_ready_once: assert property (p_ready_once) else $error("ready slip");
  a_idle_quiet: assert property (p_idle_quiet) else $error("stray ready");
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits");
  a_err_clean: assert property (p_err_clean) else $error("err data");
  a_unmapped: assert property (p_unmapped) else $error("no error");
  a_mapped: assert property (p_mapped) else $error("false error");
  a_rd_clear: assert property (p_rd_clear) else $error("data kept");
  a_irq_excl: assert property (p_irq_excl) else $error("both irq");
  a_irq_fall: assert property (p_irq_fall) else $error("irq drop");
endmodule

// ### dv/aur_rx_tb_top.sv
// Self-checking bench for the serial receiver
`timescale 1ns/100ps
`include "aur_defs.vh"
module aur_rx_tb_top;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        sleep_mode = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, receive_line, rcv_irq_high, rcv_irq_low;
  int          miscompares = 0;
  int          samples_checked = 0;
  logic [31:0] q;
  logic        e;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  aur_rx_top aur_rx_top_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .receive_line(receive_line),
    .rcv_irq_high(rcv_irq_high), .rcv_irq_low(rcv_irq_low));
  // Sixteen clocks per bit: four samples of four clocks, or sixteen samples of one clock
  aur_line_model #(.BIT_CLKS(16)) aur_line_model_inst (
    .sys_clk(sys_clk), .line(receive_line));

  // ========
  // Tasks
  task complete_run;
    $display("checked %0d wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Setup, then access held until ready is seen
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // Ready, data and error are all taken at the rising edge
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        complete_run();
      end
      @(posedge sys_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 8'h0);
    chk(q, x);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  // ========
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`AUR_OFS_RCV_STAT, 32'h00);
    rd(`AUR_OFS_TX_STAT, 32'h02);
    rd(`AUR_OFS_BAUD_CTRL, 32'h40);
    rd(`AUR_OFS_DIV_LOW, 32'h00);
    rd(12'h024, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Wide fast divisor 3, receive enabled
    wr(`AUR_OFS_TX_STAT, 8'h04);
    wr(`AUR_OFS_BAUD_CTRL, 8'h08);
    wr(`AUR_OFS_DIV_LOW, 8'h03);
    wr(`AUR_OFS_INT_ENABLES, 8'h20);
    wr(`AUR_OFS_RCV_STAT, 8'h90);
    aur_line_model_inst.frame(9'h0a5, 8, 1'b1);
    chk({31'h0, rcv_irq_low}, 32'h1);
    rd(`AUR_OFS_INT_FLAGS, 32'h20);
    rd(`AUR_OFS_RCV_DATA, 32'ha5);
    rd(`AUR_OFS_INT_FLAGS, 32'h00);
    // Sleep, then clocked mode: frame must be dropped
    for (int k = 0; k < 2; k++) begin
      sleep_mode <= (k == 0);
      wr(`AUR_OFS_TX_STAT, k ? 8'h14 : 8'h04);
      aur_line_model_inst.frame(9'h03c, 8, 1'b1);
      rd(`AUR_OFS_INT_FLAGS, 32'h00);
    end
    wr(`AUR_OFS_TX_STAT, 8'h04);
    // Nine-bit address detect at high priority
    wr(`AUR_OFS_INT_PRIO, 8'h20);
    wr(`AUR_OFS_RCV_STAT, 8'hd8);
    aur_line_model_inst.frame(9'h033, 9, 1'b1);
    rd(`AUR_OFS_INT_FLAGS, 32'h00);
    aur_line_model_inst.frame(9'h15a, 9, 1'b1);
    chk({30'h0, rcv_irq_high, rcv_irq_low}, 32'h2);
    rd(`AUR_OFS_RCV_STAT, 32'hd9);
    rd(`AUR_OFS_RCV_DATA, 32'h5a);
    wr(`AUR_OFS_RCV_STAT, 8'hd0);
    aur_line_model_inst.frame(9'h066, 9, 1'b1);
    rd(`AUR_OFS_RCV_DATA, 32'h66);
    // Low stop, then a frame into the full buffer
    wr(`AUR_OFS_RCV_STAT, 8'h90);
    aur_line_model_inst.frame(9'h0c3, 8, 1'b0);
    aur_line_model_inst.frame(9'h011, 8, 1'b1);
    rd(`AUR_OFS_RCV_STAT, 32'h96);
    rd(`AUR_OFS_RCV_DATA, 32'hc3);
    wr(`AUR_OFS_RCV_STAT, 8'h80);
    rd(`AUR_OFS_RCV_STAT, 32'h80);
    // Break wakes the port from sleep
    wr(`AUR_OFS_RCV_STAT, 8'h90);
    wr(`AUR_OFS_INT_PRIO, 8'h00);
    wr(`AUR_OFS_BAUD_CTRL, 8'h0a);
    sleep_mode <= 1'b1;
    aur_line_model_inst.brk(12);
    chk({31'h0, rcv_irq_low}, 32'h1);
    sleep_mode <= 1'b0;
    rd(`AUR_OFS_RCV_STAT, 32'h90);
    apb(1'b0, `AUR_OFS_BAUD_CTRL, 8'h0);
    chk(q & 32'h02, 32'h0);
    apb(1'b0, `AUR_OFS_RCV_DATA, 8'h0); // contents thrown away
    rd(`AUR_OFS_INT_FLAGS, 32'h00);
    aur_line_model_inst.frame(9'h081, 8, 1'b1);
    rd(`AUR_OFS_RCV_DATA, 32'h81);
    // Sixteen samples per bit on the narrow divisor, one tick a clock
    wr(`AUR_OFS_DIV_LOW, 8'h00);
    wr(`AUR_OFS_BAUD_CTRL, 8'h00);
    aur_line_model_inst.frame(9'h0b6, 8, 1'b1);
    rd(`AUR_OFS_RCV_DATA, 32'hb6);
    rd(`AUR_OFS_RCV_STAT, 32'h90);
    complete_run();
  end
endmodule

bind aur_rx_top aur_rx_chk aur_rx_chk_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rcv_irq_high(rcv_irq_high), .rcv_irq_low(rcv_irq_low));

// ### rtl/aur_baud_gen.v
// Baud generator giving one tick per receive sample
`timescale 1ns/100ps
module aur_baud_gen (
  // Clock, reset, enable
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       clk_en,
  // Configuration
  input  wire       run,
  input  wire       wide_divisor_select,
  input  wire       high_speed_baud_select,
  input  wire [7:0] div_high,
  input  wire [7:0] div_low,
  // Sample tick
  output wire       tick
);

  `include "aur_defs.vh"

  reg  [1:0]  pre_r;
  reg  [15:0] cnt_r;
  reg         tick_r;
  wire [15:0] limit;
  wire        slow;
  wire        pre_done;

  // Narrow divisor ignores the high byte
  assign limit    = wide_divisor_select ? {div_high, div_low}
                                        : {8'h00, div_low};
  // Low-speed narrow mode divides four times further
  assign slow     = ~wide_divisor_select & ~high_speed_baud_select;
  assign pre_done = ~slow | (pre_r == `AUR_PRESCALE_SLOW);

  // ==========================================================================
  // Period of (divisor + 1) * prescale clocks; stopped counter restarts clean
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_r  <= 2'h0;
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        pre_r  <= 2'h0;
        cnt_r  <= 16'h0000;
        tick_r <= 1'b0;
      end else begin
        tick_r <= 1'b0;
        pre_r  <= pre_done ? 2'h0 : pre_r + 2'h1;
        if (pre_done) begin
          if (cnt_r >= limit) begin
            cnt_r  <= 16'h0000;
            tick_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
      end
    end
  end

  assign tick = tick_r;

endmodule

// ### rtl/aur_defs.vh
// Register map, field positions, reset values and timing for the receiver
//
// Contract
// - Data recovery samples the line at sixteen times the bit rate; four times when the wide and high-speed selects are both set.
// - Asynchronous mode runs only with clocked-mode select clear and enable set.
// - Bit rate comes from the 16-bit divisor, high-speed and wide selects.
// - Nine-bit select captures a ninth data bit, else eight bits.
// - Reception needs continuous enable; clearing it clears receive errors.
// - Completed frame sets receive flag; request only when enable also set.
// - Data byte in receive data register; ninth bit, errors in status.
// - Status bits 7..0: enable, nine-bit, single, continuous, address, FE, OE, D8.
// - Address detect in nine-bit mode keeps only address frames.
// - Software picks receive interrupt priority with the priority bit.
// - In sleep the baud generator stops and no byte is received.
// - Wake-up enable at baud control bit 1 disables normal reception.
// - A falling line edge is the wake-up event while wake-up enabled.
// - Wake-up event sets the receive flag, awake or asleep.
// - Reading receive data clears the wake-up receive condition.
// - First rising edge after the event clears wake-up enable itself.
// - Receiver idle status bit shows whether a frame is in progress.
// - Unimplemented register bits read as zero.
// - Frames: start bit, 8 or 9 data bits LSB first, stop bit.
`ifndef AUR_DEFS_VH
`define AUR_DEFS_VH

// ===========================================================================
// APB byte offsets
`define AUR_OFS_RCV_STAT     12'h000
`define AUR_OFS_RCV_DATA     12'h004
`define AUR_OFS_TX_STAT      12'h008
`define AUR_OFS_BAUD_CTRL    12'h00c
`define AUR_OFS_DIV_HIGH     12'h010
`define AUR_OFS_DIV_LOW      12'h014
`define AUR_OFS_INT_FLAGS    12'h018
`define AUR_OFS_INT_ENABLES  12'h01c
`define AUR_OFS_INT_PRIO     12'h020

// ===========================================================================
// Receive status and control fields
`define AUR_RS_ENABLE        7
`define AUR_RS_NINE          6
`define AUR_RS_SINGLE        5
`define AUR_RS_CONT          4
`define AUR_RS_ADDR          3
`define AUR_RS_FRAMING_ERROR_FLAG          2
`define AUR_RS_OVERRUN_ERROR_FLAG          1
`define AUR_RS_D8            0

// Transmit status fields shared with the receive path
`define AUR_TS_SYNC          4
`define AUR_TS_HIGH_SPEED    2
`define AUR_TS_SHIFT_EMPTY   1
`define AUR_TS_WR_MASK       8'hfd

// Baud control fields
`define AUR_BC_OVERFLOW      7
`define AUR_BC_IDLE          6
`define AUR_BC_POLARITY      4
`define AUR_BC_WIDE          3
`define AUR_BC_WAKE          1
`define AUR_BC_AUTOBAUD      0
`define AUR_BC_WR_MASK       8'h9b

// Receive bit in the interrupt flag, enable and priority registers
`define AUR_INT_RCV_BIT      5

// ===========================================================================
// Reset values
`define AUR_RST_RCV_STAT     8'h00
`define AUR_RST_TX_STAT      8'h02
`define AUR_RST_BAUD_CTRL    8'h00
`define AUR_RST_DIV          8'h00

// ===========================================================================
// Timing: samples per bit and prescale of the generator
`define AUR_SPB_STD          4'hf
`define AUR_SPB_FAST         4'h3
`define AUR_MID_STD          4'h9
`define AUR_MID_FAST         4'h3
`define AUR_PRESCALE_SLOW    2'h3

`endif

// ### rtl/aur_line_sync.v
// Two-stage synchroniser and edge detector for the receive line
`timescale 1ns/100ps
module aur_line_sync (
  // Clock, reset, enable
  input  wire sys_clk,
  input  wire reset_n,
  input  wire clk_en,
  // Line in
  input  wire line_in,
  // Synchronised level and edges
  output wire line_lvl,
  output wire line_fall,
  output wire line_rise
);

  reg meta_r;
  reg sync_r;
  reg last_r;

  // ==========================================================================
  // Sync chain; idle-high reset so no false start at power-up
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else if (clk_en) begin
      meta_r <= line_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Edges compare second and third stage only
  assign line_lvl  = sync_r;
  assign line_fall = last_r & ~sync_r;
  assign line_rise = ~last_r & sync_r;

endmodule

// ### rtl/aur_rx_top.v
// Asynchronous serial receiver with address detect and wake-up, APB slave
`timescale 1ns/100ps
module aur_rx_top (
  // Clock, reset, enable
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Power state
  input  wire        sleep_mode,
  // Serial line
  input  wire        receive_line,
  // Interrupt requests
  output wire        rcv_irq_high,
  output wire        rcv_irq_low
);

  `include "aur_defs.vh"

  // ==========================================================================
  // Receiver states
  localparam ST_IDLE  = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA  = 3'h2;
  localparam ST_STOP  = 3'h3;
  localparam ST_WARM  = 3'h4;
  localparam ST_WLOW  = 3'h5;

  // Majority of three samples
  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  // Word read back for one byte register, upper bits zero
  function [31:0] word8;
    input [7:0] b;
    begin
      word8 = {24'h000000, b};
    end
  endfunction

  // ==========================================================================
  // Declarations
  reg  [7:0]  rcv_ctrl_r;     // bits 7..3 of receive status
  reg  [7:0]  tx_stat_r;
  reg  [7:0]  baud_ctrl_r;    // software bits; idle is live
  reg  [7:0]  div_high_r;
  reg  [7:0]  div_low_r;
  reg         rcv_ie_r;
  reg         rcv_ip_r;
  reg  [7:0]  buf_data_r;
  reg         buf_d8_r;
  reg         buf_full_r;
  reg         framing_error_flag_r;
  reg         overrun_error_flag_r;
  reg         wake_pend_r;
  reg  [2:0]  state_r;
  reg  [3:0]  samp_r;
  reg  [3:0]  bit_r;
  reg  [8:0]  shift_r;
  reg  [2:0]  hist_r;
  reg  [31:0] prdata_r;
  reg         pready_r;
  reg         pslverr_r;
  reg         irq_high_r;
  reg         irq_low_r;
  reg  [31:0] rd_word;
  reg         rd_hit;

  wire        line_lvl;
  wire        line_fall;
  wire        line_rise;
  wire        tick;
  wire        async_on;
  wire        rx_go;
  wire        wake_on;
  wire        nine;
  wire [3:0]  spb;
  wire [3:0]  mid;
  wire [3:0]  last_bit;
  wire        samp_now;
  wire        bit_end;
  wire        bit_val;
  wire        frame_done;
  wire        accept;
  wire        acc;
  wire        wr;
  wire        rd_data;
  wire        rcv_flag;
  wire        idle_stat;
  wire [7:0]  rcv_stat;
  wire [7:0]  baud_rd;

  // ==========================================================================
  // Sub-blocks
  aur_line_sync u_sync (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .line_in   (receive_line),
    .line_lvl  (line_lvl),
    .line_fall (line_fall),
    .line_rise (line_rise)
  );

  aur_baud_gen u_baud (
    .sys_clk                (sys_clk),
    .reset_n                (reset_n),
    .clk_en                 (clk_en),
    .run                    (rx_go),
    .wide_divisor_select    (baud_ctrl_r[`AUR_BC_WIDE]),
    .high_speed_baud_select (tx_stat_r[`AUR_TS_HIGH_SPEED]),
    .div_high               (div_high_r),
    .div_low                (div_low_r),
    .tick                   (tick)
  );

  // ==========================================================================
  // Mode decode
  assign async_on = rcv_ctrl_r[`AUR_RS_ENABLE] &
                    ~tx_stat_r[`AUR_TS_SYNC];
  // Wake watch runs without the generator, so it survives sleep
  assign wake_on  = async_on & baud_ctrl_r[`AUR_BC_WAKE];
  // Overrun halts reception until the continuous enable is cleared
  assign rx_go    = async_on & rcv_ctrl_r[`AUR_RS_CONT] & ~overrun_error_flag_r &
                    ~wake_on & ~sleep_mode;
  assign nine     = rcv_ctrl_r[`AUR_RS_NINE];
  // Both fast selects leave only four samples per bit
  assign spb      = (baud_ctrl_r[`AUR_BC_WIDE] &
                     tx_stat_r[`AUR_TS_HIGH_SPEED]) ? `AUR_SPB_FAST
                                                    : `AUR_SPB_STD;
  assign mid      = (spb == `AUR_SPB_FAST) ? `AUR_MID_FAST : `AUR_MID_STD;
  assign last_bit = nine ? 4'h8 : 4'h7;
  assign samp_now = tick & (samp_r == mid);
  assign bit_end  = tick & (samp_r == spb);
  // Vote over the mid-bit sample and the two samples before it
  assign bit_val  = maj3({hist_r[1:0], line_lvl});

  // ==========================================================================
  // APB decode
  assign acc     = psel & penable & pready_r;
  assign wr      = acc & pwrite;
  assign rd_data = acc & ~pwrite & (paddr == `AUR_OFS_RCV_DATA);

  // ==========================================================================
  // Frame completion and address filter
  assign frame_done = (state_r == ST_STOP) & samp_now;
  assign accept     = ~(nine & rcv_ctrl_r[`AUR_RS_ADDR]) | shift_r[8];
  assign rcv_flag   = buf_full_r | wake_pend_r;
  assign idle_stat  = (state_r == ST_IDLE) | (state_r == ST_WARM);
  assign rcv_stat   = {rcv_ctrl_r[7:3], framing_error_flag_r, overrun_error_flag_r, buf_d8_r};
  assign baud_rd    = (baud_ctrl_r & `AUR_BC_WR_MASK) |
                      {1'b0, idle_stat, 6'h00};

  // ==========================================================================
  // Receive state machine, shifter and wake-up watch
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      samp_r  <= 4'h0;
      bit_r   <= 4'h0;
      shift_r <= 9'h000;
      hist_r  <= 3'h7;
    end else if (clk_en) begin
      if (tick) begin
        hist_r <= {hist_r[1:0], line_lvl};
      end
      if (wake_on) begin
        samp_r <= 4'h0;
        case (state_r)
          ST_WARM: begin
            if (line_fall) begin
              state_r <= ST_WLOW;
            end
          end
          ST_WLOW: begin
            if (line_rise) begin
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_WARM;
          end
        endcase
      end else if (!rx_go) begin
        state_r <= ST_IDLE;
        samp_r  <= 4'h0;
      end else begin
        if (tick) begin
          samp_r <= (samp_r == spb) ? 4'h0 : samp_r + 4'h1;
        end
        case (state_r)
          ST_IDLE: begin
            // Start seen on a sample tick; phase error under one sample
            if (tick && !line_lvl) begin
              state_r <= ST_START;
              samp_r  <= 4'h1;
            end
          end
          ST_START: begin
            if (samp_now && bit_val) begin
              state_r <= ST_IDLE;                          // glitch reject
            end else if (bit_end) begin
              state_r <= ST_DATA;
              bit_r   <= 4'h0;
              shift_r <= 9'h000;
            end
          end
          ST_DATA: begin
            if (samp_now) begin
              shift_r[bit_r] <= bit_val;
            end
            if (bit_end) begin
              if (bit_r == last_bit) begin
                state_r <= ST_STOP;
              end else begin
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          ST_STOP: begin
            // Back to idle at mid stop so the next start is not missed
            if (samp_now) begin
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Receive buffer, error flags and wake pending
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_data_r  <= 8'h00;
      buf_d8_r    <= 1'b0;
      buf_full_r  <= 1'b0;
      framing_error_flag_r      <= 1'b0;
      overrun_error_flag_r      <= 1'b0;
      wake_pend_r <= 1'b0;
    end else if (clk_en) begin
      // Reading data pops the buffer and ends a wake-up request
      if (rd_data) begin
        buf_full_r  <= 1'b0;
        wake_pend_r <= 1'b0;
      end
      if (wake_on && state_r == ST_WARM && line_fall) begin
        wake_pend_r <= 1'b1;
      end
      if (wr && paddr == `AUR_OFS_RCV_STAT &&
          !pwdata[`AUR_RS_CONT]) begin
        overrun_error_flag_r <= 1'b0;
        framing_error_flag_r <= 1'b0;
      end
      if (frame_done && accept) begin
        // Frame landing on the read cycle still gets stored
        if (buf_full_r && !rd_data) begin
          overrun_error_flag_r <= 1'b1;
        end else begin
          buf_data_r <= shift_r[7:0];
          buf_d8_r   <= nine & shift_r[8];
          buf_full_r <= 1'b1;
          framing_error_flag_r     <= ~bit_val;
        end
      end
    end
  end

  // ==========================================================================
  // Software registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rcv_ctrl_r  <= `AUR_RST_RCV_STAT;
      tx_stat_r   <= `AUR_RST_TX_STAT;
      baud_ctrl_r <= `AUR_RST_BAUD_CTRL;
      div_high_r  <= `AUR_RST_DIV;
      div_low_r   <= `AUR_RST_DIV;
      rcv_ie_r    <= 1'b0;
      rcv_ip_r    <= 1'b0;
    end else if (clk_en) begin
      // Hardware clears wake-up enable on the rise ending the break
      if (wake_on && state_r == ST_WLOW && line_rise) begin
        baud_ctrl_r[`AUR_BC_WAKE] <= 1'b0;
      end
      if (wr) begin
        case (paddr)
          `AUR_OFS_RCV_STAT: begin
            rcv_ctrl_r <= {pwdata[7:3], 3'h0};
          end
          `AUR_OFS_TX_STAT: begin
            tx_stat_r <= (pwdata[7:0] & `AUR_TS_WR_MASK) |
                         `AUR_RST_TX_STAT;
          end
          `AUR_OFS_BAUD_CTRL: begin
            baud_ctrl_r <= pwdata[7:0] & `AUR_BC_WR_MASK;
          end
          `AUR_OFS_DIV_HIGH: begin
            div_high_r <= pwdata[7:0];
          end
          `AUR_OFS_DIV_LOW: begin
            div_low_r <= pwdata[7:0];
          end
          `AUR_OFS_INT_ENABLES: begin
            rcv_ie_r <= pwdata[`AUR_INT_RCV_BIT];
          end
          `AUR_OFS_INT_PRIO: begin
            rcv_ip_r <= pwdata[`AUR_INT_RCV_BIT];
          end
          default: begin
            rcv_ie_r <= rcv_ie_r;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Read mux; unmapped addresses answer zero with an error
  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (paddr)
      `AUR_OFS_RCV_STAT:    rd_word = word8(rcv_stat);
      `AUR_OFS_RCV_DATA:    rd_word = word8(buf_data_r);
      `AUR_OFS_TX_STAT:     rd_word = word8(tx_stat_r);
      `AUR_OFS_BAUD_CTRL:   rd_word = word8(baud_rd);
      `AUR_OFS_DIV_HIGH:    rd_word = word8(div_high_r);
      `AUR_OFS_DIV_LOW:     rd_word = word8(div_low_r);
      `AUR_OFS_INT_FLAGS:   rd_word = word8({2'h0, rcv_flag, 5'h00});
      `AUR_OFS_INT_ENABLES: rd_word = word8({2'h0, rcv_ie_r, 5'h00});
      `AUR_OFS_INT_PRIO:    rd_word = word8({2'h0, rcv_ip_r, 5'h00});
      default:              rd_hit  = 1'b0;
    endcase
  end

  // ==========================================================================
  // APB answer: data latched in setup, ready in the first access cycle
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~rd_hit;
      if (psel && !penable && !pwrite) begin
        prdata_r <= rd_word;
      end else if (acc) begin
        prdata_r <= 32'h00000000;
      end
    end
  end

  // ==========================================================================
  // Interrupt requests split by priority
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_high_r <= 1'b0;
      irq_low_r  <= 1'b0;
    end else if (clk_en) begin
      irq_high_r <= rcv_flag & rcv_ie_r & rcv_ip_r;
      irq_low_r  <= rcv_flag & rcv_ie_r & ~rcv_ip_r;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign rcv_irq_high = irq_high_r;
  assign rcv_irq_low  = irq_low_r;

endmodule
